// [logic/pwm_value_consts.svh]
`ifndef PWM_VALUE_CONSTS_SVH
`define PWM_VALUE_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PWV_OFS_CH0        12'h000
`define PWV_OFS_CH1        12'h004
`define PWV_OFS_CH2        12'h008
`define PWV_OFS_CH3        12'h00c
`define PWV_OFS_CTRL       12'h010
`define PWV_OFS_MODULUS    12'h014
`define PWV_OFS_STATUS     12'h018

// ****************************************
// control register fields
// ****************************************
`define PWV_CTRL_LOAD_OKAY 0
`define PWV_CTRL_PRESC_LO  1
`define PWV_CTRL_PRESC_HI  2
`define PWV_CTRL_POL0      3
`define PWV_CTRL_POL1      4
`define PWV_CTRL_CORR_LO   5
`define PWV_CTRL_CORR_HI   6
`define PWV_CTRL_COMP0     7
`define PWV_CTRL_COMP1     8
`define PWV_CTRL_ENABLE    9

// ****************************************
// reset values
// ****************************************
`define PWV_RST_WIDTH      16'h0000
`define PWV_RST_MODULUS    15'h0100
`define PWV_RST_PRESC      2'h0

`endif

// [logic/pwm_value_pkg.sv]
// ****************************************
// shared types
// ****************************************
package pwm_value_pkg;
    // signed pulse width in generator clock periods
    typedef logic signed [15:0] pulse_width_t;
    // counter modulus, fifteen usable bits
    typedef logic [14:0]        modulus_t;
    // correction method field
    typedef enum logic [1:0] {
        corr_none,
        corr_manual,
        corr_deadtime,
        corr_sample
    } correction_e;
endpackage : pwm_value_pkg

// [logic/pwm_pulse_width_value_regs.sv]
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
`include "pwm_value_consts.svh"

// How it works
// - four buffered signed 16-bit width registers
// - width zero or negative holds output low
// - width at or above modulus holds high
// - active drives high, inactive drives low
// - buffered width used after load-okay and reload
// - reads return buffered value, not working value
// - width registers accessible anytime, no restrictions
// - load-okay copies prescaler, modulus, widths together
// - pair polarity picks even or odd width in complementary manual correction
module pwm_pulse_width_value_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             channel_out_0,
    output logic             channel_out_1,
    output logic             channel_out_2,
    output logic             channel_out_3,
    output logic             reload_pulse
);

    // ****************************************
    // software-visible buffers
    // ****************************************
    pwm_value_pkg::pulse_width_t width_reg [4];   // buffered widths
    pwm_value_pkg::modulus_t     counter_modulus_a_reg;
    logic [1:0]                  prescaler_select_a_reg;
    logic                        load_okay_reg;
    logic                        pair0_polarity_select_reg;
    logic                        pair1_polarity_select_reg;
    pwm_value_pkg::correction_e  correction_method_select_reg;
    logic                        comp0_reg;       // pair 0 complementary
    logic                        comp1_reg;       // pair 1 complementary
    logic                        enable_reg;      // generator run

    // ****************************************
    // working copies used by the generator
    // ****************************************
    pwm_value_pkg::pulse_width_t work_width_reg [4];
    pwm_value_pkg::modulus_t     work_modulus_reg;
    logic [1:0]                  work_presc_reg;
    logic                        work_pol0_reg;
    logic                        work_pol1_reg;

    // ****************************************
    // counter and prescaler state
    // ****************************************
    pwm_value_pkg::modulus_t     count_reg;
    logic [2:0]                  presc_cnt_reg;
    logic [31:0]                 prdata_reg;
    logic                        pslverr_reg;
    logic [3:0]                  out_reg;

    // ****************************************
    // bus decode
    // ****************************************
    wire        setup_phase  = psel & ~penable;
    wire        access_phase = psel & penable;
    wire        wr_access    = access_phase & pwrite;
    wire        hit_ch0      = (paddr == `PWV_OFS_CH0);
    wire        hit_ch1      = (paddr == `PWV_OFS_CH1);
    wire        hit_ch2      = (paddr == `PWV_OFS_CH2);
    wire        hit_ch3      = (paddr == `PWV_OFS_CH3);
    wire        hit_ctrl     = (paddr == `PWV_OFS_CTRL);
    wire        hit_mod      = (paddr == `PWV_OFS_MODULUS);
    wire        hit_status   = (paddr == `PWV_OFS_STATUS);
    wire [3:0]  hit_width    = {hit_ch3, hit_ch2, hit_ch1, hit_ch0};
    wire        hit_any      = (|hit_width) | hit_ctrl | hit_mod
                               | hit_status;
    // status is read-only, so a write there is refused as well
    wire        bad_access   = ~hit_any | (pwrite & hit_status);
    wire        wr_ctrl      = wr_access & hit_ctrl;
    wire        wr_mod       = wr_access & hit_mod;

    // no wait states: the read word is prepared in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // ****************************************
    // read mux
    // ****************************************
    // widths read from the buffer, never from the working copy
    wire [31:0] ctrl_word = {22'h000000,
                             enable_reg,
                             comp1_reg,
                             comp0_reg,
                             correction_method_select_reg,
                             pair1_polarity_select_reg,
                             pair0_polarity_select_reg,
                             prescaler_select_a_reg,
                             load_okay_reg};
    wire [31:0] rd_word =
        hit_ch0    ? {16'h0000, width_reg[0]}           :
        hit_ch1    ? {16'h0000, width_reg[1]}           :
        hit_ch2    ? {16'h0000, width_reg[2]}           :
        hit_ch3    ? {16'h0000, width_reg[3]}           :
        hit_ctrl   ? ctrl_word                          :
        hit_mod    ? {17'h00000, counter_modulus_a_reg} :
        hit_status ? {13'h0000, out_reg, count_reg}     :
                     32'h00000000;

    // capture the answer during setup, hold it through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg  <= pwrite ? 32'h00000000 : rd_word;
            pslverr_reg <= bad_access;
        end
    end

    // ****************************************
    // prescaler and counter
    // ****************************************
    // prescaler divides by 1, 2, 4 or 8
    wire [2:0] presc_mask = (work_presc_reg == 2'h0) ? 3'h0 :
                            (work_presc_reg == 2'h1) ? 3'h1 :
                            (work_presc_reg == 2'h2) ? 3'h3 : 3'h7;
    wire       gen_tick   = enable_reg
                            & ((presc_cnt_reg & presc_mask) == presc_mask);
    // a modulus of zero still gives a one-tick period
    wire       period_end = (work_modulus_reg == 15'h0000)
                            | (count_reg >= work_modulus_reg - 15'h0001);
    wire       reload     = gen_tick & period_end;

    // free-running divider, held in reset while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt_reg <= 3'h0;
        end else if (!enable_reg) begin
            presc_cnt_reg <= 3'h0;
        end else begin
            presc_cnt_reg <= presc_cnt_reg + 3'h1;
        end
    end

    // up counter 0 .. modulus-1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 15'h0000;
        end else if (!enable_reg) begin
            count_reg <= 15'h0000;
        end else if (reload) begin
            count_reg <= 15'h0000;
        end else if (gen_tick) begin
            count_reg <= count_reg + 15'h0001;
        end
    end

    // ****************************************
    // buffered width registers
    // ****************************************
    // writes are taken at any time in any mode; a write in a
    // reload cycle lands in the buffer and waits for the next one
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_width
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    width_reg[ch] <= `PWV_RST_WIDTH;
                end else if (wr_access & hit_width[ch]) begin
                    width_reg[ch] <= pwdata[15:0];
                end
            end

            // the generator only sees the copy taken at reload
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    work_width_reg[ch] <= `PWV_RST_WIDTH;
                end else if (reload & load_okay_reg) begin
                    work_width_reg[ch] <= width_reg[ch];
                end
            end
        end
    endgenerate

    // ****************************************
    // control and modulus registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_select_a_reg       <= `PWV_RST_PRESC;
            pair0_polarity_select_reg    <= 1'b0;
            pair1_polarity_select_reg    <= 1'b0;
            correction_method_select_reg <= pwm_value_pkg::corr_none;
            comp0_reg                    <= 1'b0;
            comp1_reg                    <= 1'b0;
            enable_reg                   <= 1'b0;
        end else if (wr_ctrl) begin
            prescaler_select_a_reg       <=
                pwdata[`PWV_CTRL_PRESC_HI:`PWV_CTRL_PRESC_LO];
            pair0_polarity_select_reg    <= pwdata[`PWV_CTRL_POL0];
            pair1_polarity_select_reg    <= pwdata[`PWV_CTRL_POL1];
            correction_method_select_reg <= pwm_value_pkg::correction_e'(
                pwdata[`PWV_CTRL_CORR_HI:`PWV_CTRL_CORR_LO]);
            comp0_reg                    <= pwdata[`PWV_CTRL_COMP0];
            comp1_reg                    <= pwdata[`PWV_CTRL_COMP1];
            enable_reg                   <= pwdata[`PWV_CTRL_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_modulus_a_reg <= `PWV_RST_MODULUS;
        end else if (wr_mod) begin
            counter_modulus_a_reg <= pwdata[14:0];
        end
    end

    // load-okay: software sets, hardware clears after the copy;
    // a set that meets the clearing reload wins and waits a period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_okay_reg <= 1'b0;
        end else if (wr_ctrl) begin
            load_okay_reg <= pwdata[`PWV_CTRL_LOAD_OKAY];
        end else if (reload) begin
            load_okay_reg <= 1'b0;
        end
    end

    // ****************************************
    // working prescaler, modulus and polarity
    // ****************************************
    // prescaler and modulus move together with the widths; the
    // polarity bits move at every reload without load-okay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_modulus_reg <= `PWV_RST_MODULUS;
            work_presc_reg   <= `PWV_RST_PRESC;
            work_pol0_reg    <= 1'b0;
            work_pol1_reg    <= 1'b0;
        end else if (reload) begin
            if (load_okay_reg) begin
                work_modulus_reg <= counter_modulus_a_reg;
                work_presc_reg   <= prescaler_select_a_reg;
            end
            work_pol0_reg <= pair0_polarity_select_reg;
            work_pol1_reg <= pair1_polarity_select_reg;
        end
    end

    // ****************************************
    // width selection and compare
    // ****************************************
    wire manual_corr = (correction_method_select_reg
                        == pwm_value_pkg::corr_manual);
    wire pair0_sw    = comp0_reg & manual_corr;
    wire pair1_sw    = comp1_reg & manual_corr;

    // in complementary mode one width serves the whole pair; software correction lets polarity pick it
    pwm_value_pkg::pulse_width_t eff_width [4];
    assign eff_width[0] = (pair0_sw & work_pol0_reg) ? work_width_reg[1]
                                                     : work_width_reg[0];
    assign eff_width[1] = work_width_reg[1];
    assign eff_width[2] = (pair1_sw & work_pol1_reg) ? work_width_reg[3]
                                                     : work_width_reg[2];
    assign eff_width[3] = work_width_reg[3];

    wire signed [16:0] mod_s   = {2'b00, work_modulus_reg};
    wire signed [16:0] count_s = {2'b00, count_reg};
    wire [3:0]         raw_active;

    // signed compare, clamped at both ends of the period
    generate
        for (ch = 0; ch < 4; ch++) begin : g_cmp
            wire signed [16:0] w_s = {eff_width[ch][15], eff_width[ch]};
            assign raw_active[ch] =
                (w_s <= 17'sh00000) ? 1'b0 :
                (w_s >= mod_s)      ? 1'b1 :
                (count_s < w_s);
        end
    endgenerate

    // odd channel is the complement of the even in complementary mode
    wire [3:0] out_next = enable_reg ?
        {comp1_reg ? ~raw_active[2] : raw_active[3],
         raw_active[2],
         comp0_reg ? ~raw_active[0] : raw_active[1],
         raw_active[0]} : 4'h0;

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 4'h0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign channel_out_0 = out_reg[0];
    assign channel_out_1 = out_reg[1];
    assign channel_out_2 = out_reg[2];
    assign channel_out_3 = out_reg[3];
    assign reload_pulse  = reload;

endmodule : pwm_pulse_width_value_regs

// [test/pwm_value_checker.sv]
`timescale 1ns/100ps
// ****************************************
// port checker
// ****************************************
module pwm_value_checker (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        channel_out_0,
    input  wire logic        channel_out_1,
    input  wire logic        channel_out_2,
    input  wire logic        channel_out_3,
    input  wire logic        reload_pulse
);
    logic [15:0] shadow_reg [4];   // widths as software last wrote them
    logic        enable_reg;       // generator enable as last written
    logic        enable_prev_reg;  // one cycle older, covers output lag
    wire  logic  acc;              // access phase of any transfer
    wire  logic  width_hit;        // address falls on a width register
    wire  logic  [3:0] outs;       // all channel outputs
    assign acc = psel & penable;
    assign width_hit = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
    assign outs = {channel_out_3, channel_out_2, channel_out_1, channel_out_0};
    // track writes, so reads can be judged without peeking inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_reg      <= '{default: 16'h0000};
            enable_reg      <= 1'b0;
            enable_prev_reg <= 1'b0;
        end else begin
            if (acc && pwrite && width_hit)
                shadow_reg[paddr[3:2]] <= pwdata[15:0];
            if (acc && pwrite && paddr == 12'h010)
                enable_reg <= pwdata[9];
            enable_prev_reg <= enable_reg;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rd_width_a: assert property (acc && !pwrite && width_hit |->
        prdata[15:0] == shadow_reg[paddr[3:2]]) else $error("bad readback");
    width_ok_a: assert property (acc && width_hit |-> !pslverr)
        else $error("width access refused");
    unmapped_err_a: assert property (acc && paddr > 12'h018 |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped");
    status_err_a: assert property (acc && pwrite && paddr == 12'h018 |->
        pslverr) else $error("status write accepted");
    ready_high_a: assert property (acc |-> pready) else $error("wait state");
    reload_single_a: assert property (
        reload_pulse |=> !reload_pulse) else $error("reload too long");
    idle_low_a: assert property (!enable_reg && !enable_prev_reg |->
        outs == 4'h0) else $error("output active while off");
    reset_quiet_a: assert property ($rose(presetn) |-> !reload_pulse &&
        outs == 4'h0) else $error("busy after reset");
endmodule : pwm_value_checker

bind pwm_pulse_width_value_regs pwm_value_checker i_pwm_value_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_out_0(channel_out_0),
    .channel_out_1(channel_out_1), .channel_out_2(channel_out_2),
    .channel_out_3(channel_out_3), .reload_pulse(reload_pulse));

// [test/pwm_pulse_width_value_regs_tb.sv]
`timescale 1ns/100ps
module pwm_pulse_width_value_regs_tb;
    typedef struct { logic [11:0] a; logic [31:0] d; logic [15:0] q; } row_s;
    logic        pclk = 1'b0;      // 40 MHz bus clock
    logic        presetn = 1'b0;   // held low at start
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  outs;             // channel outputs, bit k is channel k
    logic        reload_pulse;
    logic [31:0] q;                // last read data
    logic        e;                // last error flag
    int          err_count = 0;
    int          checked = 0;
    int          len;              // measured period in cycles
    int          hi [4];           // active cycles per channel
    // upper bits of the last row must be ignored by the width field
    row_s rows [4] = '{'{12'h000, 32'h8000, 16'h8000},
        '{12'h004, 32'h7fff, 16'h7fff}, '{12'h008, 32'hffff, 16'hffff},
        '{12'h00c, 32'habcd1234, 16'h1234}};
    logic [15:0] wv [4] = '{16'hfffd, 16'h0000, 16'h0008, 16'h0003};
    pwm_pulse_width_value_regs i_pwm_pulse_width_value_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .channel_out_0(outs[0]),
        .channel_out_1(outs[1]), .channel_out_2(outs[2]),
        .channel_out_3(outs[3]), .reload_pulse(reload_pulse));
    // ****************************************
    // clock and bus tasks
    // ****************************************
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // setup cycle, then access held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // outputs are sampled mid-cycle on the falling edge, away from the rising edge
    task automatic sync_reload;
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        // the first period after enable runs at the reset modulus
        end while (reload_pulse !== 1'b1 && n < 300);
        chk(n < 300, 1'b1);
    endtask : sync_reload
    // first period after a change may straddle, so skip one
    task automatic measure;
        sync_reload;
        sync_reload;
        len = 0;
        hi = '{0, 0, 0, 0};
        do begin
            @(negedge pclk);
            len++;
            for (int k = 0; k < 4; k++) hi[k] += (outs[k] === 1'b1);
        end while (reload_pulse !== 1'b1 && len < 100);
    endtask : measure
    task automatic complete_run;
        $display("errors %0d, checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0); chk(q, 32'h0);
        apb(1'b0, 12'h014, 32'h0); chk(q & 32'h7fff, 32'h100);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(q[15:0], rows[i].q);
        end
        // modulus 8, widths -3, 0, 8, 3, then enable with load okay
        apb(1'b1, 12'h014, 32'h8);
        foreach (wv[i]) apb(1'b1, 12'(i * 4), {16'h0, wv[i]});
        apb(1'b1, 12'h010, 32'h201);
        measure;
        chk(len, 8);
        chk(hi[0], 0);
        chk(hi[1], 0);
        chk(hi[2], 8);
        chk(hi[3], 3);
        // new width without load okay stays in the buffer
        apb(1'b1, 12'h00c, 32'h5);
        apb(1'b1, 12'h010, 32'h200);
        measure;
        chk(hi[3], 3);
        apb(1'b0, 12'h00c, 32'h0); chk(q[15:0], 16'h0005);
        // modulus 6, divide by 2, loaded together
        apb(1'b1, 12'h014, 32'h6);
        apb(1'b1, 12'h010, 32'h203);
        measure;
        chk(len, 12);
        chk(hi[3], 10);
        chk(hi[2], 12);
        // both pairs in manual correction, polarity one, new ch1 width
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b1, 12'h010, 32'h3bb);
        measure;
        chk(hi[0], 6);
        chk(hi[1], 6);
        chk(hi[2], 10);
        chk(hi[3], 2);
        // polarity zero, pair 0 independent, divide by 4 loaded
        apb(1'b1, 12'h010, 32'h325);
        measure;
        chk(len, 24);
        chk(hi[0], 0);
        chk(hi[1], 12);
        chk(hi[2], 24);
        chk(hi[3], 0);
        // refused accesses
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, 12'h018, 32'hffff);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 12'h010, 32'h0);
        repeat (3) @(negedge pclk);
        chk({28'h0, outs}, 32'h0);
        // mid-run reset brings width buffers and control back to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h00c, 32'h0); chk(q, 32'h0);
        apb(1'b0, 12'h010, 32'h0); chk(q, 32'h0);
        complete_run;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        err_count++;
        complete_run;
    end
endmodule : pwm_pulse_width_value_regs_tb
